// file: verilog/csv_pkg.sv
// Package for the configuration and status vector port.
// Assumes a single datapath clock shared by the block, its user logic and AHB-Lite.
package csv_pkg;

    // Vector widths
    localparam int CFG_W  = 7;
    localparam int STAT_W = 8;
    localparam int LANES  = 4;
    localparam int EVT_W  = 4;

    // Configuration vector fields
    localparam int CFG_SEL_HI    = 6;
    localparam int CFG_SEL_LO    = 5;
    localparam int CFG_TEST_EN   = 4;
    localparam int CFG_LINK_REL  = 3;
    localparam int CFG_FAULT_CLR = 2;
    localparam int CFG_PWR_DOWN  = 1;
    localparam int CFG_LOOPBACK  = 0;

    // Status vector fields
    localparam int STAT_LINK     = 7;
    localparam int STAT_ALIGN    = 6;
    localparam int STAT_SYNC_HI  = 5;
    localparam int STAT_SYNC_LO  = 2;
    localparam int STAT_RX_FAULT = 1;
    localparam int STAT_TX_FAULT = 0;

    // Test pattern selection codes
    typedef enum logic [1:0] {
        CSV_PAT_HIGH  = 2'h0,
        CSV_PAT_LOW   = 2'h1,
        CSV_PAT_MIXED = 2'h2,
        CSV_PAT_RSVD  = 2'h3
    } csv_pattern_e;

    // Interrupt event bits
    localparam int EVT_TX_FAULT  = 0;
    localparam int EVT_RX_FAULT  = 1;
    localparam int EVT_LINK_DOWN = 2;
    localparam int EVT_ALIGN_LOS = 3;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS     = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h08;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;

    // STATUS register layout
    localparam int REG_STAT_LO = 0;
    localparam int REG_CFG_LO  = 8;

    // Reset values
    localparam logic [STAT_W-1:0] RST_STATUS  = 8'h00;
    localparam logic [CFG_W-1:0]  RST_CONFIG  = 7'h00;
    localparam logic [EVT_W-1:0]  RST_IRQ_EN  = 4'h0;
    localparam logic              RST_LATCH   = 1'b0;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

// file: verilog/csv_edge_latch.sv
// Latched status bit with a rising-edge clear request.
// Assumes event and request come from flip-flops on the same clock.
`timescale 1ns/10ps
module csv_edge_latch #(
    parameter bit LATCH_LOW = 1'b0
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Condition and request
    input  wire logic cond,
    input  wire logic req,
    // Latched result
    output logic      latched
);

    logic req_d_reg;
    logic hit_reg;
    logic req_edge;
    logic hit;

    // RQ17 previous-cycle compare
    assign req_edge = req & ~req_d_reg;

    // Latch-low flavour tracks the absence of the condition
    assign hit = LATCH_LOW ? ~cond : cond;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_d_reg <= csv_pkg::RST_LATCH;
        end else begin
            req_d_reg <= req;
        end
    end

    // RQ15 persisting condition wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Both flavours leave reset with latched at its reset value
            hit_reg <= LATCH_LOW ^ csv_pkg::RST_LATCH;
        end else begin
            hit_reg <= hit | (hit_reg & ~req_edge);
        end
    end

    assign latched = LATCH_LOW ? ~hit_reg : hit_reg;

endmodule

// file: verilog/csv_irq.sv
// Sticky interrupt status, enable mask and one level interrupt.
// Assumes clear and enable writes arrive as one-cycle strobes.
`timescale 1ns/10ps
module csv_irq #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Events
    input  wire logic [N-1:0] event_pulse,
    // Software access
    input  wire logic         clr_we,
    input  wire logic [N-1:0] clr_data,
    input  wire logic         en_we,
    input  wire logic [N-1:0] en_data,
    // State
    output logic      [N-1:0] pend,
    output logic      [N-1:0] enable,
    output logic              irq
);

    logic [N-1:0] clr_mask;

    assign clr_mask = clr_we ? clr_data : '0;

    // A new event in the clearing cycle survives the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= '0;
        end else begin
            pend <= event_pulse | (pend & ~clr_mask);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable <= '0;
        end else if (en_we) begin
            enable <= en_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pend & enable);
        end
    end

endmodule

// file: verilog/csv_port.sv
// Configuration and status vector port with an AHB-Lite register view.
// Assumes user logic, core status and the bus all run on hclk.
//
// Notes on behaviour
// RQ1 - Take a 7-bit configuration vector and give an 8-bit status vector.
// RQ2 - Configuration bits 6:5 choose the transmit test pattern.
// RQ3 - Pattern codes: 00 high, 01 low, 10 mixed, 11 reserved.
// RQ4 - Configuration bit 4 enables the selected pattern; zero means no pattern.
// RQ5 - Rising edge of configuration bit 2 clears both latched fault bits.
// RQ6 - User logic drives configuration bit 2 from a flop on this clock.
// RQ7 - Configuration bit 1 puts the transceivers into power-down.
// RQ8 - Configuration bit 0 puts the transceivers into serial loopback.
// RQ9 - Status bit 7 shows link up and latches low once it drops.
// RQ10 - Rising edge of configuration bit 3 releases the latched-low link bit.
// RQ11 - Status bit 6 shows four-lane alignment and drives the align output.
// RQ12 - Status bits 5:2 show lane sync and drive the sync output.
// RQ13 - Status bit 1 latches a receive fault until cleared by bit 2.
// RQ14 - Status bit 0 latches a transmit fault until cleared by bit 2.
// RQ15 - A fault bit stays set while its fault persists.
// RQ16 - User logic registers every signal to and from this block.
// RQ17 - Edges on bits 2 and 3 found by compare with previous cycle.
`timescale 1ns/10ps
module csv_port #(
    parameter int LANES = csv_pkg::LANES
) (
    // Clock and reset
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // Configuration vector from user logic
    input  wire logic [csv_pkg::CFG_W-1:0]   configuration_vector,
    // Status from the receive and transmit paths
    input  wire logic                        rx_link_up,
    input  wire logic                        rx_aligned,
    input  wire logic [LANES-1:0]            rx_lane_sync,
    input  wire logic                        rx_fault,
    input  wire logic                        tx_fault,
    // Status vector and side outputs
    output logic      [csv_pkg::STAT_W-1:0]  status_vector,
    output logic                             align_status,
    output logic      [LANES-1:0]            sync_status,
    // Transceiver and pattern controls
    output logic      [1:0]                  test_pattern_sel,
    output logic                             test_pattern_en,
    output logic                             xcvr_power_down,
    output logic                             xcvr_loopback,
    // Interrupt
    output logic                             irq,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp
);

    localparam int EW = csv_pkg::EVT_W;

    logic                       link_latched;
    logic                       rx_fault_latched;
    logic                       tx_fault_latched;
    logic                       align_reg;
    logic [LANES-1:0]           sync_reg;
    logic [csv_pkg::STAT_W-1:0] status_next;
    logic [csv_pkg::STAT_W-1:0] status_prev_reg;
    logic [EW-1:0]              events;
    logic [EW-1:0]              irq_pend;
    logic [EW-1:0]              irq_enable;
    logic                       irq_level;
    logic                       addr_ok;
    logic                       wr_pend_reg;
    logic [7:0]                 wr_addr_reg;
    logic [31:0]                rd_next;
    logic                       clr_we;
    logic                       en_we;

    // RQ5 RQ13 receive fault latch
    csv_edge_latch #(
        .LATCH_LOW (1'b0)
    ) u_rx_fault (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cond    (rx_fault),
        .req     (configuration_vector[csv_pkg::CFG_FAULT_CLR]),
        .latched (rx_fault_latched)
    );

    // RQ5 RQ14 transmit fault latch
    csv_edge_latch #(
        .LATCH_LOW (1'b0)
    ) u_tx_fault (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cond    (tx_fault),
        .req     (configuration_vector[csv_pkg::CFG_FAULT_CLR]),
        .latched (tx_fault_latched)
    );

    // RQ9 link latches low, RQ10 released by bit 3
    csv_edge_latch #(
        .LATCH_LOW (1'b1)
    ) u_link (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cond    (rx_link_up),
        .req     (configuration_vector[csv_pkg::CFG_LINK_REL]),
        .latched (link_latched)
    );

    // Live alignment and sync are staged once so every status bit is a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            align_reg <= 1'b0;
            sync_reg  <= '0;
        end else begin
            align_reg <= rx_aligned;
            sync_reg  <= rx_lane_sync;
        end
    end

    // RQ1 status vector assembly
    always_comb begin
        status_next = csv_pkg::RST_STATUS;
        status_next[csv_pkg::STAT_LINK] = link_latched;
        status_next[csv_pkg::STAT_ALIGN] = align_reg;
        status_next[csv_pkg::STAT_SYNC_HI:csv_pkg::STAT_SYNC_LO] = sync_reg;
        status_next[csv_pkg::STAT_RX_FAULT] = rx_fault_latched;
        status_next[csv_pkg::STAT_TX_FAULT] = tx_fault_latched;
    end

    // RQ11 RQ12 shared status drive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_vector <= csv_pkg::RST_STATUS;
            align_status  <= 1'b0;
            sync_status   <= '0;
        end else begin
            status_vector <= status_next;
            align_status  <= status_next[csv_pkg::STAT_ALIGN];
            sync_status   <= status_next[csv_pkg::STAT_SYNC_HI:csv_pkg::STAT_SYNC_LO];
        end
    end

    // RQ2 RQ4 pattern controls; reserved code generates nothing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_pattern_sel <= csv_pkg::CSV_PAT_HIGH;
            test_pattern_en  <= 1'b0;
        end else begin
            test_pattern_sel <= configuration_vector[csv_pkg::CFG_SEL_HI:csv_pkg::CFG_SEL_LO];
            // RQ3 reserved code blocked
            test_pattern_en  <= configuration_vector[csv_pkg::CFG_TEST_EN]
                && (configuration_vector[csv_pkg::CFG_SEL_HI:csv_pkg::CFG_SEL_LO]
                    != csv_pkg::CSV_PAT_RSVD);
        end
    end

    // RQ7 RQ8 transceiver controls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xcvr_power_down <= 1'b0;
            xcvr_loopback   <= 1'b0;
        end else begin
            xcvr_power_down <= configuration_vector[csv_pkg::CFG_PWR_DOWN];
            xcvr_loopback   <= configuration_vector[csv_pkg::CFG_LOOPBACK];
        end
    end

    // Events are edges of the presented status, so each raises one pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_prev_reg <= csv_pkg::RST_STATUS;
        end else begin
            status_prev_reg <= status_vector;
        end
    end

    always_comb begin
        events = '0;
        events[csv_pkg::EVT_TX_FAULT] = status_vector[csv_pkg::STAT_TX_FAULT]
            & ~status_prev_reg[csv_pkg::STAT_TX_FAULT];
        events[csv_pkg::EVT_RX_FAULT] = status_vector[csv_pkg::STAT_RX_FAULT]
            & ~status_prev_reg[csv_pkg::STAT_RX_FAULT];
        events[csv_pkg::EVT_LINK_DOWN] = ~status_vector[csv_pkg::STAT_LINK]
            & status_prev_reg[csv_pkg::STAT_LINK];
        events[csv_pkg::EVT_ALIGN_LOS] = ~status_vector[csv_pkg::STAT_ALIGN]
            & status_prev_reg[csv_pkg::STAT_ALIGN];
    end

    csv_irq #(
        .N (EW)
    ) u_irq (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .event_pulse (events),
        .clr_we      (clr_we),
        .clr_data    (hwdata[EW-1:0]),
        .en_we       (en_we),
        .en_data     (hwdata[EW-1:0]),
        .pend        (irq_pend),
        .enable      (irq_enable),
        .irq         (irq_level)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_level;
        end
    end

    // Bus slave: zero wait states; read data is fetched in the address phase
    assign addr_ok = hsel && hready && (htrans == csv_pkg::HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite && (hsize == csv_pkg::HSIZE_WORD);
            wr_addr_reg <= haddr[7:0];
        end
    end

    assign clr_we = wr_pend_reg && (wr_addr_reg == csv_pkg::OFS_IRQ_CLEAR);
    assign en_we  = wr_pend_reg && (wr_addr_reg == csv_pkg::OFS_IRQ_ENABLE);

    // Unmapped and write-only offsets read as zero
    always_comb begin
        rd_next = 32'h0000_0000;
        case (haddr[7:0])
            csv_pkg::OFS_STATUS: begin
                rd_next[csv_pkg::REG_STAT_LO +: csv_pkg::STAT_W] = status_vector;
                rd_next[csv_pkg::REG_CFG_LO +: csv_pkg::CFG_W] = configuration_vector;
            end
            csv_pkg::OFS_IRQ_STATUS: begin
                rd_next[EW-1:0] = irq_pend;
            end
            csv_pkg::OFS_IRQ_ENABLE: begin
                rd_next[EW-1:0] = irq_enable;
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= csv_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= csv_pkg::HRESP_OKAY;
        end
    end

endmodule

// file: sim/csv_port_asserts.sv
// Assertion checker on the pins of csv_port, bound into every instance.
// Assumes hclk is the only clock and hresetn the active-low reset.
`timescale 1ns/10ps
module csv_port_asserts #(
    parameter int LANES = 4
) (
    // Clock and reset
    input wire logic                        hclk,
    input wire logic                        hresetn,
    // Watched inputs
    input wire logic [csv_pkg::CFG_W-1:0]   configuration_vector,
    input wire logic                        rx_link_up,
    input wire logic                        rx_aligned,
    input wire logic [LANES-1:0]            rx_lane_sync,
    input wire logic                        rx_fault,
    input wire logic                        tx_fault,
    // Watched outputs
    input wire logic [csv_pkg::STAT_W-1:0]  status_vector,
    input wire logic                        align_status,
    input wire logic [LANES-1:0]            sync_status,
    input wire logic [1:0]                  test_pattern_sel,
    input wire logic                        test_pattern_en,
    input wire logic                        xcvr_power_down,
    input wire logic                        xcvr_loopback,
    input wire logic                        hreadyout,
    input wire logic                        hresp
);
    logic [1:0] cfg_q;
    logic [1:0] edge_q;
    logic [1:0] up_cnt;
    // Edges of bits 3:2, one cycle late, as the latches act on them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q  <= 2'h0;
            edge_q <= 2'h0;
        end else begin
            cfg_q  <= configuration_vector[3:2];
            edge_q <= configuration_vector[3:2] & ~cfg_q;
        end
    end
    // Pipeline checks wait, so inputs seen during reset are never compared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence fault_clr_s;
        $rose(configuration_vector[2]) && !tx_fault && !rx_fault;
    endsequence
    sequence link_rel_s;
        $rose(configuration_vector[3]) && rx_link_up;
    endsequence
    chk_ctrl_copy: assert property (up_cnt != 2'h0 |-> {test_pattern_sel, xcvr_power_down,
        xcvr_loopback} == {$past(configuration_vector[6:5]), $past(configuration_vector[1:0])})
        else $error("control outputs differ from configuration");
    chk_pattern_en: assert property (up_cnt != 2'h0 |-> test_pattern_en ==
        ($past(configuration_vector[4]) && $past(configuration_vector[6:5]) != 2'h3))
        else $error("pattern enable wrong");
    chk_tx_latch: assert property (tx_fault |-> ##2 status_vector[0])
        else $error("transmit fault not latched");
    chk_rx_latch: assert property (rx_fault |-> ##2 status_vector[1])
        else $error("receive fault not latched");
    chk_fault_hold: assert property (!edge_q[0] |=>
        &(status_vector[1:0] | ~$past(status_vector[1:0])))
        else $error("fault bit cleared without clear edge");
    chk_fault_clear: assert property (fault_clr_s |-> ##2 status_vector[1:0] == 2'h0)
        else $error("fault bits not cleared");
    chk_link_hold: assert property (!status_vector[7] && !edge_q[1] |=> !status_vector[7])
        else $error("link bit rose without release");
    chk_link_drop: assert property (!rx_link_up |-> ##2 !status_vector[7])
        else $error("link loss not latched");
    chk_link_release: assert property (link_rel_s |-> ##2 status_vector[7])
        else $error("link bit not released");
    chk_align_path: assert property (up_cnt[1] |->
        status_vector[6] == $past(rx_aligned, 2) && align_status == status_vector[6])
        else $error("alignment status wrong");
    chk_sync_path: assert property (up_cnt[1] |->
        status_vector[5:2] == $past(rx_lane_sync, 2) && sync_status == status_vector[5:2])
        else $error("lane sync status wrong");
    chk_bus_okay: assert property (hreadyout && hresp == csv_pkg::HRESP_OKAY)
        else $error("bus response not ready okay");
endmodule

bind csv_port csv_port_asserts #(.LANES(LANES)) i_csv_port_asserts (
    .hclk(hclk), .hresetn(hresetn), .configuration_vector(configuration_vector),
    .rx_link_up(rx_link_up), .rx_aligned(rx_aligned), .rx_lane_sync(rx_lane_sync),
    .rx_fault(rx_fault), .tx_fault(tx_fault), .status_vector(status_vector),
    .align_status(align_status), .sync_status(sync_status),
    .test_pattern_sel(test_pattern_sel), .test_pattern_en(test_pattern_en),
    .xcvr_power_down(xcvr_power_down), .xcvr_loopback(xcvr_loopback),
    .hreadyout(hreadyout), .hresp(hresp)
);

// file: sim/csv_user_model.sv
// User-side model: hands the port a configuration vector from a flop.
// Assumes the bench sets the wanted vector on cfg_req, all on hclk.
`timescale 1ns/10ps
module csv_user_model (
    // Clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // Wanted and registered vector
    input  wire logic [csv_pkg::CFG_W-1:0] cfg_req,
    output logic      [csv_pkg::CFG_W-1:0] configuration_vector
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            configuration_vector <= 7'h00;
        end else begin
            configuration_vector <= cfg_req;
        end
    end
endmodule

// file: sim/tb.sv
// Self-checking bench for csv_port: vectors, latches and register view.
// Assumes a 50 MHz hclk and the zero-wait AHB-Lite slave of csv_port.
`timescale 1ns/10ps
module tb;
    logic                      hclk, hresetn, link, algn, rxf, txf, hsel, hwrite;
    logic [csv_pkg::CFG_W-1:0] cfg_req, cfg;
    logic [3:0]                lsync, syn_o;
    logic [7:0]                sv;
    logic [1:0]                sel, htrans;
    logic                      aln_o, pen, pdn, lpb, irq, hreadyout, hresp;
    logic [31:0]               haddr, hwdata, hrdata, rd;
    int                        n_mismatch, comparisons;

    csv_user_model i_csv_user_model (.hclk(hclk), .hresetn(hresetn), .cfg_req(cfg_req),
        .configuration_vector(cfg));
    csv_port i_csv_port (.hclk(hclk), .hresetn(hresetn), .configuration_vector(cfg),
        .rx_link_up(link), .rx_aligned(algn), .rx_lane_sync(lsync), .rx_fault(rxf),
        .tx_fault(txf), .status_vector(sv), .align_status(aln_o), .sync_status(syn_o),
        .test_pattern_sel(sel), .test_pattern_en(pen), .xcvr_power_down(pdn),
        .xcvr_loopback(lpb), .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(csv_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'h1 && k < 20);
        if (hreadyout !== 1'h1) begin
            n_mismatch++;
            conclude();
        end
    endtask
    // One single word transfer; the answer is taken at the data phase's edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'h1;
        htrans <= csv_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    // Status paths need three edges: user flop, latch, vector; the task waits six
    task automatic set_cfg(input logic [6:0] v);
        cfg_req <= v;
        repeat (6) @(posedge hclk);
    endtask
    task automatic t_reset();
        check("status", sv, 8'h00);
        ahb(1'h0, csv_pkg::OFS_STATUS, 32'h0);
        check("reg_status", rd, 32'h0);
        ahb(1'h0, 8'h10, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask
    task automatic t_ctrl();
        logic [6:0] v;
        for (int p = 0; p < 5; p++) begin
            v = {p[1:0], p != 4, 2'h0, p[1:0]};
            set_cfg(v);
            check("sel", sel, p[1:0]);
            check("pat_en", pen, p < 3);
            check("pwr_down", pdn, p[1]);
            check("loopback", lpb, p[0]);
            ahb(1'h0, csv_pkg::OFS_STATUS, 32'h0);
            check("cfg_view", rd[14:8], v);
        end
        set_cfg(7'h00);
    endtask
    task automatic t_link();
        link <= 1'h1;
        set_cfg(7'h08);
        check("link_rel", sv[7], 1'h1);
        link <= 1'h0;
        @(posedge hclk);
        link <= 1'h1;
        repeat (4) @(posedge hclk);
        check("link_low", sv[7], 1'h0);
        set_cfg(7'h00);
        set_cfg(7'h08);
        check("link_rel2", sv[7], 1'h1);
    endtask
    task automatic t_lanes();
        for (int i = 0; i < 4; i++) begin
            algn  <= i[0];
            lsync <= 4'h5 << i;
            repeat (4) @(posedge hclk);
            check("align", {aln_o, sv[6]}, {2{i[0]}});
            check("sync", {syn_o, sv[5:2]}, {2{4'h5 << i}});
        end
    endtask
    task automatic t_fault();
        txf <= 1'h1;
        @(posedge hclk);
        txf <= 1'h0;
        repeat (8) @(posedge hclk);
        check("tx_latch", sv[1:0], 2'h1);
        rxf <= 1'h1;
        set_cfg(7'h04);
        check("clr_busy", sv[1:0], 2'h2);
        rxf <= 1'h0;
        repeat (4) @(posedge hclk);
        check("clr_held", sv[1:0], 2'h2);
        set_cfg(7'h00);
        set_cfg(7'h04);
        check("clr_done", sv[1:0], 2'h0);
    endtask
    task automatic t_irq();
        ahb(1'h1, csv_pkg::OFS_IRQ_CLEAR, 32'hF);
        ahb(1'h1, csv_pkg::OFS_IRQ_ENABLE, 32'h1);
        ahb(1'h1, 8'h10, 32'hF);
        ahb(1'h0, csv_pkg::OFS_IRQ_ENABLE, 32'h0);
        check("irq_en", rd, 32'h1);
        txf <= 1'h1;
        @(posedge hclk);
        txf <= 1'h0;
        repeat (8) @(posedge hclk);
        check("irq_set", irq, 1'h1);
        ahb(1'h0, csv_pkg::OFS_IRQ_STATUS, 32'h0);
        check("irq_stat", rd[0], 1'h1);
        ahb(1'h1, csv_pkg::OFS_IRQ_ENABLE, 32'h0);
        repeat (3) @(posedge hclk);
        check("irq_mask", irq, 1'h0);
        ahb(1'h1, csv_pkg::OFS_IRQ_ENABLE, 32'h1);
        ahb(1'h1, csv_pkg::OFS_IRQ_CLEAR, 32'h1);
        repeat (3) @(posedge hclk);
        check("irq_clr", irq, 1'h0);
        ahb(1'h0, csv_pkg::OFS_IRQ_STATUS, 32'h0);
        check("irq_stat0", rd[0], 1'h0);
    endtask
    // Reset in mid-run drops every latch, whatever it held before
    task automatic t_rst2();
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        check("rst_status", sv, 8'h00);
        repeat (4) @(posedge hclk);
        check("rst_latch", {sv[7], sv[1:0], irq}, 4'h0);
    endtask

    initial begin
        hclk = 1'h0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        {hresetn, link, algn, rxf, txf, hsel, hwrite, htrans, lsync} = '0;
        {cfg_req, haddr, hwdata, n_mismatch, comparisons} = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_reset();
        t_ctrl();
        t_link();
        t_lanes();
        t_fault();
        t_irq();
        t_rst2();
        conclude();
    end
endmodule
